// *** core/dcpc_pkg.sv ***
// ------------------------------------------------------------------
// ------------------------------------------------------------------
package dcpc_pkg;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned NUM_ASYNC = 4;
   localparam int unsigned NUM_ITX = 8;
   // Async context control ports and command pointers.
   localparam logic [11:0] ACTL_SET_BASE = 12'h180;
   localparam logic [11:0] ACTL_CLR_BASE = 12'h184;
   localparam logic [11:0] ASYNC_STRIDE = 12'h020;
   localparam logic [11:0] ASYNC_TX_REQUEST_CMD_PTR_OFS = 12'h18C;
   localparam logic [11:0] ASYNC_TX_RESPONSE_CMD_PTR_OFS = 12'h1AC;
   localparam logic [11:0] ASYNC_RX_REQUEST_CMD_PTR_OFS = 12'h1CC;
   localparam logic [11:0] ASYNC_RX_RESPONSE_CMD_PTR_OFS = 12'h1EC;
   // Iso transmit context control ports.
   localparam logic [11:0] ITX_CTRL_SET_OFS = 12'h200;
   localparam logic [11:0] ITX_CTRL_CLR_OFS = 12'h204;
   localparam logic [11:0] ITX_STRIDE = 12'h010;
   // Field positions.
   localparam int unsigned PTR_ADDR_LSB = 4;
   localparam int unsigned BIT_CME = 31;
   localparam int unsigned BIT_RUN = 15;
   localparam int unsigned BIT_WAKE = 12;
   localparam int unsigned BIT_DEAD = 11;
   localparam int unsigned BIT_ACTIVE = 10;
   localparam logic [31:0] ITX_SC_MASK = 32'hFFFF_8000;
   // Reset values.
   localparam logic [31:0] PTR_RESET = 32'h0000_0000;
   localparam logic [31:0] ITX_SC_RESET = 32'h0000_0000;
   localparam logic [7:0] EVT_RESET = 8'h00;
   // Bus responses.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      KIND_NONE, KIND_ACTL_SET, KIND_ACTL_CLR, KIND_PTR, KIND_ITX_SET, KIND_ITX_CLR
   } dcpc_kind_t;

   typedef struct packed {
      dcpc_kind_t kind;
      logic [2:0] idx;
   } dcpc_dec_t;

   typedef enum logic {FETCH_IDLE, FETCH_REQ} dcpc_fetch_t;

   // Maps a byte address to a register kind and context index.
   function automatic dcpc_dec_t dcpc_decode(input logic [ADDR_W-1:0] a);
      logic [3:0][11:0] ptrs;
      dcpc_dec_t d;
      ptrs = {ASYNC_RX_RESPONSE_CMD_PTR_OFS, ASYNC_RX_REQUEST_CMD_PTR_OFS,
              ASYNC_TX_RESPONSE_CMD_PTR_OFS, ASYNC_TX_REQUEST_CMD_PTR_OFS};
      d.kind = KIND_NONE;
      d.idx = 3'h0;
      for (int i = 0; i < NUM_ASYNC; i++) begin
         if (a == 12'(ACTL_SET_BASE + i * ASYNC_STRIDE)) begin
            d.kind = KIND_ACTL_SET;
            d.idx = 3'(i);
         end
         if (a == 12'(ACTL_CLR_BASE + i * ASYNC_STRIDE)) begin
            d.kind = KIND_ACTL_CLR;
            d.idx = 3'(i);
         end
         if (a == ptrs[i]) begin
            d.kind = KIND_PTR;
            d.idx = 3'(i);
         end
      end
      for (int i = 0; i < NUM_ITX; i++) begin
         if (a == 12'(ITX_CTRL_SET_OFS + i * ITX_STRIDE)) begin
            d.kind = KIND_ITX_SET;
            d.idx = 3'(i);
         end
         if (a == 12'(ITX_CTRL_CLR_OFS + i * ITX_STRIDE)) begin
            d.kind = KIND_ITX_CLR;
            d.idx = 3'(i);
         end
      end
      return d;
   endfunction

   // Expands byte strobes to a bit mask.
   function automatic logic [31:0] dcpc_strb_mask(input logic [3:0] s);
      return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction
endpackage

// *** core/dcpc_itx_ctx.sv ***
`timescale 1ns/100ps
module dcpc_itx_ctx (
   // Clock and reset.
   input wire logic clk,
   input wire logic nrst,
   input wire logic soft_rst,
   // Register port, data already masked by strobes.
   input wire logic wr_set,
   input wire logic wr_clr,
   input wire logic [31:0] wr_data,
   // Transmit engine status.
   input wire logic desc_fetch,
   input wire logic busy,
   input wire logic evt_we,
   input wire logic [7:0] evt_code,
   input wire logic dead_set,
   input wire logic [14:0] cycle_now,
   // Register value and start gate.
   output logic [31:0] ctrl,
   output logic tx_go
);
   import dcpc_pkg::*;

   logic [31:0] sc_q;
   logic [31:0] sc_d;
   logic wake_q;
   logic dead_q;
   logic act_q;
   logic act_d;
   logic go_q;
   logic [7:0] evt_q;

   // Set and clear ports touch bits 31-15 here, and set also wake below; soft reset drops run.
   always_comb begin
      sc_d = (sc_q | ({32{wr_set}} & wr_data & ITX_SC_MASK))
             & ~({32{wr_clr}} & wr_data & ITX_SC_MASK);
      if (soft_rst) begin
         sc_d[BIT_RUN] = 1'b0;
      end
      act_d = busy & sc_d[BIT_RUN];
      // An active context no longer waits, so its gate is dropped; a gate written
      // in this very cycle survives for one cycle, so the write is not lost.
      if (act_d && !(wr_set && wr_data[BIT_CME])) begin
         sc_d[BIT_CME] = 1'b0;
      end
   end

   // Software-owned bits.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sc_q <= ITX_SC_RESET;
      end else begin
         sc_q <= sc_d;
      end
   end

   // Device-updated status bits; wake is set-only from software.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wake_q <= 1'b0;
         dead_q <= 1'b0;
         act_q <= 1'b0;
         evt_q <= EVT_RESET;
      end else begin
         wake_q <= (wake_q & ~desc_fetch) | (wr_set & wr_data[BIT_WAKE]);
         dead_q <= (dead_q & sc_d[BIT_RUN]) | dead_set;
         act_q <= act_d;
         if (evt_we) begin
            evt_q <= evt_code;
         end
      end
   end

   // Start gate waits for the programmed cycle while the gate bit is on.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         go_q <= 1'b0;
      end else begin
         go_q <= sc_q[BIT_RUN] & (~sc_q[BIT_CME] | (cycle_now == sc_q[30:16]));
      end
   end

   assign ctrl = {sc_q[31:15], 2'b00, wake_q, dead_q, act_q, 2'b00, evt_q};
   assign tx_go = go_q;

   AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (!nrst)
      ctrl[14:13] == 2'b00 && ctrl[9:8] == 2'b00)
      else $error("reserved control bits not zero");
   AST_CLR_KEEPS_WAKE: assert property (@(posedge clk) disable iff (!nrst)
      wr_clr && wake_q && !desc_fetch |=> wake_q)
      else $error("clear port dropped wake");
   AST_CME_DROP: assert property (@(posedge clk) disable iff (!nrst)
      $rose(act_q) && !$past(wr_set && wr_data[BIT_CME]) |-> !sc_q[BIT_CME])
      else $error("cycle gate not cleared on activation");
   AST_CME_ACTIVE: assert property (@(posedge clk) disable iff (!nrst)
      act_q && !$past(wr_set && wr_data[BIT_CME]) |-> !sc_q[BIT_CME])
      else $error("cycle gate still set while context active");
   AST_GATE_HOLD: assert property (@(posedge clk) disable iff (!nrst)
      sc_q[BIT_CME] && !wr_set && !wr_clr && !act_d && cycle_now != sc_q[30:16]
      |=> !tx_go)
      else $error("start gate opened off cycle");
endmodule

// *** core/dcpc_top.sv ***
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/100ps
module dcpc_top (
   // Clock and resets.
   input wire logic clk,
   input wire logic nrst,
   input wire logic soft_rst,
   // AXI4-Lite write channels.
   input wire logic [dcpc_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read channels.
   input wire logic [dcpc_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Async descriptor block fetch toward host memory.
   output logic fetch_valid,
   input wire logic fetch_ready,
   output logic [31:0] fetch_addr,
   output logic [3:0] fetch_count,
   output logic [1:0] fetch_ctx,
   // Async engine status.
   input wire logic [3:0] async_dead_set,
   input wire logic [3:0] ptr_upd,
   input wire logic [31:0] ptr_upd_value,
   // Iso transmit engine.
   input wire logic [7:0] itx_desc_fetch,
   input wire logic [7:0] itx_busy,
   input wire logic [7:0] itx_evt_we,
   input wire logic [7:0][7:0] itx_evt_code,
   input wire logic [7:0] itx_dead_set,
   input wire logic [14:0] cycle_now,
   output logic [7:0] itx_tx_go
);
   import dcpc_pkg::*;

   // ------------------------------------------------------------------
   // Bus slave
   // ------------------------------------------------------------------
   logic aw_have_q;
   logic [ADDR_W-1:0] aw_addr_q;
   logic w_have_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [1:0] rresp_q;
   logic [31:0] rdata_q;
   logic wr_fire;
   logic [31:0] wmask;
   logic [31:0] wm;
   dcpc_dec_t wdec;
   dcpc_dec_t rdec;

   // Address and data are caught in either order; the write happens once both are held.
   assign s_axi_awready = ~aw_have_q & ~bvalid_q;
   assign s_axi_wready = ~w_have_q & ~bvalid_q;
   assign wr_fire = aw_have_q & w_have_q & ~bvalid_q;
   assign wdec = dcpc_decode(aw_addr_q);
   assign rdec = dcpc_decode(s_axi_araddr);
   assign wmask = dcpc_strb_mask(w_strb_q);
   assign wm = w_data_q & wmask;

   // Write address and data holding.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         aw_have_q <= 1'b0;
         aw_addr_q <= '0;
         w_have_q <= 1'b0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_have_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_have_q <= 1'b0;
         end
      end
   end

   // Write response; unmapped writes are dropped and answered with an error.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         bresp_q <= (wdec.kind == KIND_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;

   // ------------------------------------------------------------------
   // Async context state
   // ------------------------------------------------------------------
   logic [3:0][31:0] ptr_q;
   logic [3:0] run_q;
   logic [3:0] run_d;
   logic [3:0] wake_q;
   logic [3:0] act_q;
   logic [3:0] dead_q;
   logic [3:0] pend_q;
   logic [3:0] actl_set;
   logic [3:0] actl_clr;
   logic [3:0] ptr_wr;
   logic [7:0] itx_set;
   logic [7:0] itx_clr;
   logic [3:0] wake_sw;
   logic [3:0] acc_v;
   logic [3:0] zero_cnt;
   logic run_wr_any;

   // One-hot write strobes per register, decoded from the held address.
   always_comb begin
      actl_set = 4'h0;
      actl_clr = 4'h0;
      ptr_wr = 4'h0;
      itx_set = 8'h00;
      itx_clr = 8'h00;
      if (wr_fire) begin
         unique case (wdec.kind)
            KIND_ACTL_SET: actl_set[wdec.idx[1:0]] = 1'b1;
            KIND_ACTL_CLR: actl_clr[wdec.idx[1:0]] = 1'b1;
            KIND_PTR: ptr_wr[wdec.idx[1:0]] = 1'b1;
            KIND_ITX_SET: itx_set[wdec.idx] = 1'b1;
            KIND_ITX_CLR: itx_clr[wdec.idx] = 1'b1;
            KIND_NONE: begin
            end
         endcase
      end
   end

   // Run moves only on software writes or resets, never on engine events.
   always_comb begin
      run_d = (run_q | ({4{wm[BIT_RUN]}} & actl_set))
              & ~({4{wm[BIT_RUN]}} & actl_clr) & ~{4{soft_rst}};
      wake_sw = {4{wm[BIT_WAKE]}} & actl_set;
      acc_v = (fetch_valid && fetch_ready) ? 4'(4'b0001 << fetch_ctx) : 4'h0;
      run_wr_any = |((actl_set | actl_clr) & {4{wm[BIT_RUN]}});
      for (int i = 0; i < NUM_ASYNC; i++) begin
         zero_cnt[i] = (ptr_q[i][PTR_ADDR_LSB-1:0] == 4'h0);
      end
   end

   // Control bits; a wake written in a fetch's accept cycle wins over its clear.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         run_q <= 4'h0;
         wake_q <= 4'h0;
         act_q <= 4'h0;
         dead_q <= 4'h0;
      end else begin
         run_q <= run_d;
         wake_q <= (wake_q & ~acc_v) | wake_sw;
         act_q <= (act_q | acc_v) & run_d;
         dead_q <= (dead_q & run_d) | async_dead_set;
      end
   end

   // A start is pending from the run edge, or a wake while running, until the fetch goes.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pend_q <= 4'h0;
      end else begin
         pend_q <= ((pend_q & ~acc_v & ~zero_cnt) | (run_d & ~run_q) | (wake_sw & run_d))
                   & run_d;
      end
   end

   // Command pointers; an engine update wins over a software write in the same cycle.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ptr_q <= {NUM_ASYNC{PTR_RESET}};
      end else begin
         for (int i = 0; i < NUM_ASYNC; i++) begin
            if (ptr_upd[i]) begin
               ptr_q[i] <= ptr_upd_value;
            end else if (ptr_wr[i]) begin
               ptr_q[i] <= (ptr_q[i] & ~wmask) | wm;
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // Descriptor block fetch
   // ------------------------------------------------------------------
   dcpc_fetch_t fst_q;
   logic [3:0] elig;
   logic [1:0] pick;
   logic fv_q;
   logic [31:0] faddr_q;
   logic [3:0] fcnt_q;
   logic [1:0] fctx_q;

   // Lowest-numbered eligible context goes first; a zero count is never eligible.
   always_comb begin
      elig = pend_q & ~zero_cnt;
      pick = 2'h0;
      for (int i = NUM_ASYNC - 1; i >= 0; i--) begin
         if (elig[i]) begin
            pick = 2'(i);
         end
      end
   end

   // One request at a time; it is held steady until memory takes it.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         fst_q <= FETCH_IDLE;
         fv_q <= 1'b0;
         faddr_q <= 32'h0000_0000;
         fcnt_q <= 4'h0;
         fctx_q <= 2'h0;
      end else begin
         unique case (fst_q)
            FETCH_IDLE: begin
               if (|elig) begin
                  fst_q <= FETCH_REQ;
                  fv_q <= 1'b1;
                  faddr_q <= {ptr_q[pick][31:PTR_ADDR_LSB], 4'h0};
                  fcnt_q <= ptr_q[pick][PTR_ADDR_LSB-1:0];
                  fctx_q <= pick;
               end
            end
            FETCH_REQ: begin
               if (fetch_ready) begin
                  fst_q <= FETCH_IDLE;
                  fv_q <= 1'b0;
               end
            end
         endcase
      end
   end

   assign fetch_valid = fv_q;
   assign fetch_addr = faddr_q;
   assign fetch_count = fcnt_q;
   assign fetch_ctx = fctx_q;

   // ------------------------------------------------------------------
   // Iso transmit contexts
   // ------------------------------------------------------------------
   logic [7:0][31:0] itx_ctrl;

   // One control register per context.
   for (genvar g = 0; g < NUM_ITX; g++) begin : g_itx
      dcpc_itx_ctx u_ctx (
         .clk(clk),
         .nrst(nrst),
         .soft_rst(soft_rst),
         .wr_set(itx_set[g]),
         .wr_clr(itx_clr[g]),
         .wr_data(wm),
         .desc_fetch(itx_desc_fetch[g]),
         .busy(itx_busy[g]),
         .evt_we(itx_evt_we[g]),
         .evt_code(itx_evt_code[g]),
         .dead_set(itx_dead_set[g]),
         .cycle_now(cycle_now),
         .ctrl(itx_ctrl[g]),
         .tx_go(itx_tx_go[g])
      );
   end

   // ------------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------------
   logic [31:0] rd_val;

   // Set and clear ports read back the same value.
   always_comb begin
      rd_val = 32'h0000_0000;
      unique case (rdec.kind)
         KIND_ACTL_SET, KIND_ACTL_CLR: begin
            rd_val[BIT_RUN] = run_q[rdec.idx[1:0]];
            rd_val[BIT_WAKE] = wake_q[rdec.idx[1:0]];
            rd_val[BIT_DEAD] = dead_q[rdec.idx[1:0]];
            rd_val[BIT_ACTIVE] = act_q[rdec.idx[1:0]];
         end
         KIND_PTR: rd_val = ptr_q[rdec.idx[1:0]];
         KIND_ITX_SET, KIND_ITX_CLR: rd_val = itx_ctrl[rdec.idx];
         KIND_NONE: rd_val = 32'h0000_0000;
      endcase
   end

   // Read answer one cycle after the address is taken, held until rready.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rvalid_q <= 1'b0;
         rresp_q <= RESP_OKAY;
         rdata_q <= 32'h0000_0000;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_q <= 1'b1;
         rresp_q <= (rdec.kind == KIND_NONE) ? RESP_SLVERR : RESP_OKAY;
         rdata_q <= rd_val;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   assign s_axi_arready = ~rvalid_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rresp = rresp_q;
   assign s_axi_rdata = rdata_q;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   AST_FETCH_ALIGN: assert property (@(posedge clk) disable iff (!nrst)
      fetch_valid |-> fetch_addr[3:0] == 4'h0)
      else $error("fetch address not 16-byte aligned");
   AST_FETCH_NONZERO: assert property (@(posedge clk) disable iff (!nrst)
      $rose(fetch_valid) |-> fetch_count != 4'h0 && run_q[fetch_ctx])
      else $error("fetch issued for invalid pointer");
   AST_FETCH_HOLD: assert property (@(posedge clk) disable iff (!nrst)
      fetch_valid && !fetch_ready |=> fetch_valid && $stable(fetch_addr)
      && $stable(fetch_count) && $stable(fetch_ctx))
      else $error("fetch request changed before accept");
   AST_WAKE_CLR: assert property (@(posedge clk) disable iff (!nrst)
      fetch_valid && fetch_ready && !wake_sw[fetch_ctx] |=> !wake_q[fetch_ctx])
      else $error("wake not cleared by fetch");
   AST_RUN_SW_ONLY: assert property (@(posedge clk) disable iff (!nrst)
      run_q != $past(run_q) |-> $past(run_wr_any || soft_rst))
      else $error("run changed without software");
   AST_START_FETCH: assert property (@(posedge clk) disable iff (!nrst)
      fst_q == FETCH_IDLE && |elig |=> fetch_valid && fetch_addr[31:4] ==
      $past(ptr_q[pick][31:4]))
      else $error("fetch not issued from pointer");
   AST_B_AFTER_WRITE: assert property (@(posedge clk) disable iff (!nrst)
      wr_fire |=> s_axi_bvalid ##0 !s_axi_awready && !s_axi_wready)
      else $error("write response missing");
   AST_UNMAPPED_RD: assert property (@(posedge clk) disable iff (!nrst)
      s_axi_arvalid && s_axi_arready && rdec.kind == KIND_NONE
      |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
      else $error("unmapped read not refused");
endmodule

// *** verification/dcpc_mem_model.sv ***
`timescale 1ns/100ps
// ----------------------------------------
// Host memory answering block fetches
// ----------------------------------------
module dcpc_mem_model (
   // Clock and reset.
   input wire logic clk,
   input wire logic nrst,
   // Fetch handshake.
   input wire logic fetch_valid,
   output logic fetch_ready,
   input wire logic [31:0] fetch_addr,
   input wire logic [3:0] fetch_count,
   input wire logic [1:0] fetch_ctx,
   // Log of accepted fetches.
   output logic [31:0] n_fetch,
   output logic [37:0] last_fetch
);
   logic [1:0] wait_q;
   logic busy_q;
   // Stalls 2 to 5 cycles, 0 to 3 of them random, so both quick and slow answers occur.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         fetch_ready <= 1'b0;
         busy_q <= 1'b0;
         wait_q <= 2'h0;
         n_fetch <= 32'h0000_0000;
         last_fetch <= '0;
      end else if (fetch_ready) begin
         fetch_ready <= 1'b0;
         busy_q <= 1'b0;
         n_fetch <= n_fetch + 32'h0000_0001;
         last_fetch <= {fetch_addr, fetch_count, fetch_ctx};
      end else if (busy_q) begin
         if (wait_q == 2'h0) fetch_ready <= 1'b1;
         wait_q <= wait_q - 2'h1;
      end else if (fetch_valid) begin
         busy_q <= 1'b1;
         wait_q <= 2'($urandom_range(3));
      end
   end
endmodule

// *** verification/dcpc_top_tb.sv ***
`timescale 1ns/100ps
// ----------------------------------------
// Bench for the context control block
// ----------------------------------------
module dcpc_top_tb;
   logic clk, nrst, soft_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, fetch_valid, fetch_ready;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, ptr_upd_value, n_fetch, s_axi_rdata, fetch_addr, v, nf;
   logic [31:0] ev [8];
   logic [3:0] s_axi_wstrb, fetch_count;
   logic [7:0] itx_desc_fetch, itx_busy, itx_evt_we, itx_tx_go, itx_dead_set;
   logic [7:0][7:0] itx_evt_code;
   logic [14:0] cycle_now;
   logic [1:0] s_axi_bresp, s_axi_rresp, fetch_ctx;
   logic [37:0] last_fetch;
   int errors, compares;
   dcpc_top dut_u (.clk, .nrst, .soft_rst, .s_axi_awaddr, .s_axi_awprot(3'h0),
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .fetch_valid, .fetch_ready, .fetch_addr, .fetch_count,
      .fetch_ctx, .async_dead_set(4'h0), .ptr_upd(4'h0), .ptr_upd_value, .itx_desc_fetch,
      .itx_busy, .itx_evt_we, .itx_evt_code, .itx_dead_set, .cycle_now, .itx_tx_go);
   dcpc_mem_model mem_u (.clk, .nrst, .fetch_valid, .fetch_ready, .fetch_addr,
      .fetch_count, .fetch_ctx, .n_fetch, .last_fetch);
   // Free-running 40 MHz clock.
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Cycle timer and pointer update data wander at random.
   always @(posedge clk) begin
      cycle_now <= 15'($urandom());
      ptr_upd_value <= $urandom();
   end
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Readies are sampled mid-cycle, so each channel is released exactly when taken.
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw_t, w_t;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(negedge clk);
         aw_t = s_axi_awvalid & s_axi_awready;
         w_t = s_axi_wvalid & s_axi_wready;
         @(posedge clk);
         if (aw_t) s_axi_awvalid <= 1'b0;
         if (w_t) s_axi_wvalid <= 1'b0;
      end while ((s_axi_awvalid & !aw_t) | (s_axi_wvalid & !w_t));
      do @(negedge clk); while (!s_axi_bvalid);
      chk(64'(s_axi_bresp), 64'(er));
      @(posedge clk);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(negedge clk); while (!s_axi_arready);
      @(posedge clk);
      s_axi_arvalid <= 1'b0;
      do @(negedge clk); while (!s_axi_rvalid);
      chk(64'(s_axi_rdata), 64'(e));
      chk(64'(s_axi_rresp), 64'(er));
      @(posedge clk);
      s_axi_rready <= 1'b0;
   endtask
   task automatic stop_test;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Watchdog: the whole run needs a few hundred cycles at most.
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      stop_test;
   end
   // Main sequence.
   initial begin
      {nrst, soft_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, itx_desc_fetch, itx_busy, itx_evt_we, itx_dead_set} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, itx_evt_code} = '0;
      s_axi_wstrb = 4'hf;
      void'($urandom(32'ha6b5));
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      // Counts 15 and 0 are the boundary cases; 0 must start no fetch.
      for (int i = 0; i < 4; i++) begin
         v = $urandom();
         v[3:0] = (i == 3) ? 4'h0 : (i == 2) ? 4'hf : 4'(1 + $urandom_range(13));
         nf = n_fetch;
         wr(12'h18c + 12'(32 * i), v, 2'h0);
         rd_chk(12'h18c + 12'(32 * i), v, 2'h0);
         wr(12'h180 + 12'(32 * i), 32'h0000_8000, 2'h0);
         repeat (12) @(posedge clk);
         chk(64'(n_fetch - nf), 64'(i != 3));
         if (i != 3) chk(64'(last_fetch), {v[31:4], 4'h0, v[3:0], 2'(i)});
         wr(12'h184 + 12'(32 * i), 32'h0000_8000, 2'h0);
      end
      $display("test async pointers done");
      for (int n = 0; n < 8; n++) begin
         v = $urandom();
         wr(12'h200 + 12'(16 * n), v, 2'h0);
         ev[n] = v & 32'hffff_9000;
         rd_chk(12'h204 + 12'(16 * n), ev[n], 2'h0);
         v = $urandom();
         wr(12'h204 + 12'(16 * n), v, 2'h0);
         ev[n] = ev[n] & ~(v & 32'hffff_8000);
         rd_chk(12'h200 + 12'(16 * n), ev[n], 2'h0);
         itx_desc_fetch <= 8'(1 << n);
         itx_evt_we <= 8'(1 << n);
         itx_dead_set <= 8'(1 << n);
         itx_evt_code[n] <= 8'(17 * n + 3);
         @(posedge clk);
         itx_desc_fetch <= 8'h00;
         itx_evt_we <= 8'h00;
         itx_dead_set <= 8'h00;
         ev[n] = (ev[n] & 32'hffff_efff) | 32'(17 * n + 3);
         // The engine's dead flag only survives while run is on.
         if (ev[n][15]) ev[n] = ev[n] | 32'h0000_0800;
         rd_chk(12'h200 + 12'(16 * n), ev[n], 2'h0);
      end
      soft_rst <= 1'b1;
      @(posedge clk);
      soft_rst <= 1'b0;
      // Soft reset drops run, and dead goes with it.
      for (int n = 0; n < 8; n++) begin
         rd_chk(12'h200 + 12'(16 * n), ev[n] & 32'hffff_77ff, 2'h0);
      end
      $display("test iso control done");
      itx_busy <= 8'h01;
      wr(12'h200, 32'h8000_8000, 2'h0);
      repeat (2) @(posedge clk);
      rd_chk(12'h200, (ev[0] & 32'h7fff_00ff) | 32'h0000_8400, 2'h0);
      chk(64'(itx_tx_go[0]), 64'h1);
      rd_chk(12'h280, 32'h0000_0000, 2'h2);
      wr(12'h100, 32'hffff_ffff, 2'h2);
      $display("test activation and unmapped done");
      stop_test;
   end
endmodule
